// >>> rtl/cce_cfg.svh
`ifndef CCE_CFG_SVH
`define CCE_CFG_SVH

// ****************************************
// Field values and reset values
// ****************************************
`define CCE_DEST_ACC   1'b0
`define CCE_DEST_MEM   1'b1
`define CCE_ZERO_BYTE  8'h00
`define CCE_ACC_RST    8'h00
`define CCE_ZERO_RST   1'b0
`define CCE_PC_RST     13'h0000
`define CCE_WDOG_RST   16'h0000
`define CCE_PC_STEP    13'h0001
`define CCE_DEC_STEP   8'h01

`endif

// >>> rtl/cce_pkg.sv
package cce_pkg;

    // ****************************************
    // Instruction selector driven by the decoder
    // ****************************************
    typedef enum logic [2:0] {
        CCE_OP_NONE       = 3'h0,
        CCE_OP_CALL       = 3'h1,
        CCE_OP_CLEAR      = 3'h2,
        CCE_OP_WDOG_CLEAR = 3'h3,
        CCE_OP_COMPLEMENT = 3'h4,
        CCE_OP_DECREMENT  = 3'h5,
        CCE_OP_DEC_SKIP   = 3'h6
    } cce_op_e;

    // ****************************************
    // Execution sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        CCE_ST_IDLE = 4'b0001,
        CCE_ST_EXEC = 4'b0010,
        CCE_ST_CALL = 4'b0100,
        CCE_ST_SKIP = 4'b1000
    } cce_state_e;

endpackage : cce_pkg

// >>> rtl/cce_mem_if.sv
`timescale 1ns/100ps

interface cce_mem_if;
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cce_mem_if

// >>> rtl/cce_data_ram.sv
`timescale 1ns/100ps

module cce_data_ram #(
    parameter int DEPTH = 256
) (
    // Clock
    input  wire logic clk_i,
    // Access port
    cce_mem_if.mem    mif
);
    logic [7:0] mem_q [DEPTH];

    // ****************************************
    // Storage, registered read
    // ****************************************
    // Read during write returns the old byte
    always_ff @(posedge clk_i) begin
        if (mif.we) begin
            mem_q[mif.waddr] <= mif.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        mif.rdata <= mem_q[mif.raddr];
    end
endmodule : cce_data_ram

// >>> rtl/cce_exec.sv
`timescale 1ns/100ps
`include "cce_cfg.svh"

// Notes on behaviour
// - Call pushes program counter plus one onto the return stack, flags untouched.
// - Call then loads program counter with immediate target; two cycles in total.
// - Clear-byte writes zero to addressed byte, no flags, one cycle.
// - Watchdog-clear resets the watchdog counter to zero, flags untouched.
// - Complement inverts byte, destination bit picks accumulator or memory, sets zero.
// - Decrement subtracts one, destination bit picks accumulator or memory, sets zero.
// - Decrement-and-skip stores per destination bit and leaves every flag alone.
// - Decrement-and-skip skips the following instruction when its result is zero.
// - A skip discards the fetched instruction and runs a no-operation instead.
module cce_exec import cce_pkg::*; #(
    parameter int PC_W  = 13,
    parameter int WDOG_W = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Instruction request
    input  wire logic             req_valid_i,
    input  wire cce_op_e          op_i,
    input  wire logic [7:0]       addr_i,
    input  wire logic             dest_i,
    input  wire logic [PC_W-1:0]  target_i,
    input  wire logic [PC_W-1:0]  pc_i,
    // Sequencing
    output logic                  ready_o,
    output logic                  done_o,
    output logic                  skip_o,
    // Core state
    output logic [7:0]            acc_o,
    output logic                  zero_o,
    // Program flow
    output logic                  push_o,
    output logic [PC_W-1:0]       push_data_o,
    output logic                  pc_load_o,
    output logic [PC_W-1:0]       pc_o,
    // Watchdog
    output logic [WDOG_W-1:0]     watchdog_counter_o
);
    cce_mem_if  mif ();
    cce_state_e state_q, state_d;
    cce_op_e    op_q;
    logic [7:0] addr_q;
    logic       dest_q;
    logic [PC_W-1:0] target_q;
    logic [7:0] result;
    logic       accept;
    logic       exec;

    function automatic logic [7:0] cce_alu(input cce_op_e op, input logic [7:0] val);
        if (op == CCE_OP_COMPLEMENT) begin
            return ~val;
        end
        return val - `CCE_DEC_STEP;
    endfunction : cce_alu

    function automatic logic cce_sets_zero(input cce_op_e op);
        return (op == CCE_OP_COMPLEMENT) || (op == CCE_OP_DECREMENT);
    endfunction : cce_sets_zero

    cce_data_ram #(.DEPTH(256)) u_ram (
        .clk_i (clk_i),
        .mif   (mif.mem)
    );

    assign accept = req_valid_i && ready_o;
    assign exec   = (state_q == CCE_ST_EXEC);
    assign result = cce_alu(op_q, mif.rdata);

    // ****************************************
    // Data memory access
    // ****************************************
    always_comb begin
        mif.raddr = addr_i;
        mif.we    = 1'b0;
        mif.waddr = addr_q;
        mif.wdata = result;
        if (accept && op_i == CCE_OP_CLEAR) begin
            mif.we    = 1'b1;
            mif.waddr = addr_i;
            mif.wdata = `CCE_ZERO_BYTE;
        end else if (exec && dest_q == `CCE_DEST_MEM) begin
            mif.we = 1'b1;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            CCE_ST_IDLE: begin
                if (accept) begin
                    case (op_i)
                        CCE_OP_CALL:       state_d = CCE_ST_CALL;
                        CCE_OP_COMPLEMENT,
                        CCE_OP_DECREMENT,
                        CCE_OP_DEC_SKIP:   state_d = CCE_ST_EXEC;
                        default:           state_d = CCE_ST_IDLE;
                    endcase
                end
            end
            CCE_ST_EXEC: begin
                if (op_q == CCE_OP_DEC_SKIP && result == `CCE_ZERO_BYTE) begin
                    state_d = CCE_ST_SKIP;
                end else begin
                    state_d = CCE_ST_IDLE;
                end
            end
            CCE_ST_CALL: state_d = CCE_ST_IDLE;
            CCE_ST_SKIP: state_d = CCE_ST_IDLE;
            default:     state_d = CCE_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= CCE_ST_IDLE;
            ready_o <= 1'b1;
        end else begin
            state_q <= state_d;
            ready_o <= (state_d == CCE_ST_IDLE);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            op_q     <= CCE_OP_NONE;
            addr_q   <= `CCE_ZERO_BYTE;
            dest_q   <= `CCE_DEST_ACC;
            target_q <= PC_W'(`CCE_PC_RST);
        end else if (accept) begin
            op_q     <= op_i;
            addr_q   <= addr_i;
            dest_q   <= dest_i;
            target_q <= target_i;
        end
    end

    // Done marks the last cycle of every instruction, including the idle slot of a skip
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
            skip_o <= 1'b0;
        end else begin
            done_o <= (accept && (op_i == CCE_OP_CLEAR || op_i == CCE_OP_WDOG_CLEAR))
                   || (exec && state_d == CCE_ST_IDLE)
                   || state_q == CCE_ST_CALL || state_q == CCE_ST_SKIP;
            skip_o <= exec && state_d == CCE_ST_SKIP;
        end
    end

    // ****************************************
    // Accumulator and zero flag
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_o <= `CCE_ACC_RST;
        end else if (exec && dest_q == `CCE_DEST_ACC) begin
            acc_o <= result;
        end
    end

    // Skip variant, call, clear and watchdog clear leave the flag alone
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zero_o <= `CCE_ZERO_RST;
        end else if (exec && cce_sets_zero(op_q)) begin
            zero_o <= (result == `CCE_ZERO_BYTE);
        end
    end

    // ****************************************
    // Call: push, then load
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            push_o      <= 1'b0;
            push_data_o <= PC_W'(`CCE_PC_RST);
        end else begin
            push_o <= accept && op_i == CCE_OP_CALL;
            if (accept && op_i == CCE_OP_CALL) begin
                push_data_o <= pc_i + PC_W'(`CCE_PC_STEP);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_load_o <= 1'b0;
            pc_o      <= PC_W'(`CCE_PC_RST);
        end else begin
            pc_load_o <= (state_q == CCE_ST_CALL);
            if (state_q == CCE_ST_CALL) begin
                pc_o <= target_q;
            end
        end
    end

    // ****************************************
    // Watchdog counter
    // ****************************************
    // Wraps freely; the timeout compare lives outside this block
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            watchdog_counter_o <= WDOG_W'(`CCE_WDOG_RST);
        end else if (accept && op_i == CCE_OP_WDOG_CLEAR) begin
            watchdog_counter_o <= WDOG_W'(`CCE_WDOG_RST);
        end else begin
            watchdog_counter_o <= watchdog_counter_o + WDOG_W'(1);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    call_push_a : assert property (accept && op_i == CCE_OP_CALL |=>
        push_o && push_data_o == $past(pc_i) + PC_W'(1) && $stable(zero_o))
        else $error("call did not push pc plus one");

    call_load_a : assert property (push_o |=> pc_load_o && pc_o == $past(target_q)
        && done_o && ready_o)
        else $error("call did not load target in two cycles");

    clear_write_a : assert property (accept && op_i == CCE_OP_CLEAR |->
        mif.we && mif.wdata == 8'h00 && mif.waddr == addr_i ##1 done_o && $stable(zero_o))
        else $error("clear byte wrong");

    watchdog_clear_a : assert property (accept && op_i == CCE_OP_WDOG_CLEAR |=>
        watchdog_counter_o == '0 && $stable(zero_o) ##1 watchdog_counter_o ==
        ($past(accept && op_i == CCE_OP_WDOG_CLEAR) ? WDOG_W'(0) : WDOG_W'(1)))
        else $error("watchdog counter not cleared");

    comp_dest_a : assert property (exec && op_q == CCE_OP_COMPLEMENT && !dest_q |=>
        acc_o == ~$past(mif.rdata) && done_o)
        else $error("complement to accumulator wrong");

    dec_mem_a : assert property (exec && op_q == CCE_OP_DECREMENT && dest_q |->
        mif.we && mif.wdata == mif.rdata - 8'h01 ##1 $stable(acc_o))
        else $error("decrement to memory wrong");

    skip_flag_a : assert property (exec && op_q == CCE_OP_DEC_SKIP |=> $stable(zero_o))
        else $error("skip variant changed zero flag");

    skip_taken_a : assert property (exec && op_q == CCE_OP_DEC_SKIP && mif.rdata == 8'h01
        |=> skip_o && !done_o && !ready_o ##1 done_o && ready_o)
        else $error("zero result did not skip");

    no_skip_a : assert property (exec && op_q == CCE_OP_DEC_SKIP && mif.rdata != 8'h01
        |=> !skip_o && done_o && ready_o)
        else $error("non-zero result skipped");

    zero_flag_a : assert property (exec && cce_sets_zero(op_q) |=>
        zero_o == (($past(op_q) == CCE_OP_COMPLEMENT) ? ($past(mif.rdata) == 8'hff)
        : ($past(mif.rdata) == 8'h01)))
        else $error("zero flag mismatch");
endmodule : cce_exec

// >>> testbench/cce_exec_tb_top.sv
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
end

module cce_exec_tb_top import cce_pkg::*; ;
    // ****************************************
    // Design hookup
    // ****************************************
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        req_valid_i = 1'b0;
    cce_op_e     op_i = CCE_OP_NONE;
    logic [7:0]  addr_i = 8'h00;
    logic        dest_i = 1'b0;
    logic [12:0] target_i = 13'h0000;
    logic [12:0] pc_i = 13'h0000;
    logic        ready_o, done_o, skip_o, zero_o, push_o, pc_load_o;
    logic [7:0]  acc_o;
    logic [12:0] push_data_o, pc_o;
    logic [15:0] watchdog_counter_o;
    logic [15:0] wdog_done;
    int          fails = 0;
    int          checked = 0;
    int          done_n, push_n, skip_n, load_n, busy_n;

    always #25 clk_i = ~clk_i;

    cce_exec uut (
        .clk_i              (clk_i),
        .rst_b_i            (rst_b_i),
        .req_valid_i        (req_valid_i),
        .op_i               (op_i),
        .addr_i             (addr_i),
        .dest_i             (dest_i),
        .target_i           (target_i),
        .pc_i               (pc_i),
        .ready_o            (ready_o),
        .done_o             (done_o),
        .skip_o             (skip_o),
        .acc_o              (acc_o),
        .zero_o             (zero_o),
        .push_o             (push_o),
        .push_data_o        (push_data_o),
        .pc_load_o          (pc_load_o),
        .pc_o               (pc_o),
        .watchdog_counter_o (watchdog_counter_o)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // Records the cycle of each pulse, counted from the taking edge
    task automatic go(input cce_op_e op, input logic [7:0] a, input logic d,
                      input logic [12:0] tg, input logic [12:0] p);
        req_valid_i = 1'b1;
        op_i        = op;
        addr_i      = a;
        dest_i      = d;
        target_i    = tg;
        pc_i        = p;
        done_n = 0;
        push_n = 0;
        skip_n = 0;
        load_n = 0;
        busy_n = 0;
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        for (int n = 1; n <= 8 && done_n == 0; n++) begin
            if (push_o === 1'b1) push_n = n;
            if (skip_o === 1'b1) skip_n = n;
            if (pc_load_o === 1'b1) load_n = n;
            if (ready_o === 1'b0) busy_n++;
            if (done_o === 1'b1) begin
                done_n   = n;
                wdog_done = watchdog_counter_o;
            end else begin
                @(posedge clk_i);
                #1;
            end
        end
        if (done_n == 0) begin
            fails++;
            $display("Error done_o expected 1 seen 0");
            stop_test();
        end
        // Idle edge so the next request never shares a time step
        @(posedge clk_i);
        #1;
    endtask : go

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        `CHK("ready_o", 1'b1, ready_o)
        `CHK("acc_o", 8'h00, acc_o)
        `CHK("zero_o", 1'b0, zero_o)
        `CHK("done_o", 1'b0, done_o)
    endtask : t_reset

    task automatic t_call();
        go(CCE_OP_CALL, 8'h00, 1'b0, 13'h1fff, 13'h0abc);
        `CHK("push_cycle", 1, push_n)
        `CHK("push_data_o", 13'h0abd, push_data_o)
        `CHK("load_cycle", 2, load_n)
        `CHK("call_done", 2, done_n)
        `CHK("call_busy", 1, busy_n)
        `CHK("pc_o", 13'h1fff, pc_o)
        `CHK("zero_o", 1'b0, zero_o)
    endtask : t_call

    task automatic t_clear_comp();
        go(CCE_OP_CLEAR, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("clear_done", 1, done_n)
        `CHK("clear_busy", 0, busy_n)
        // Cleared byte complemented into the accumulator
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'hff, acc_o)
        `CHK("zero_o", 1'b0, zero_o)
        `CHK("comp_done", 2, done_n)
        `CHK("comp_busy", 1, busy_n)
        // Memory destination leaves the accumulator alone
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b1, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'hff, acc_o)
        `CHK("zero_o", 1'b0, zero_o)
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'h00, acc_o)
        `CHK("zero_o", 1'b1, zero_o)
        go(CCE_OP_CLEAR, 8'h20, 1'b0, 13'h0000, 13'h0000);
        `CHK("zero_o", 1'b1, zero_o)
    endtask : t_clear_comp

    task automatic t_watchdog();
        go(CCE_OP_WDOG_CLEAR, 8'h00, 1'b0, 13'h0000, 13'h0000);
        `CHK("watchdog_done", 1, done_n)
        `CHK("watchdog_counter_o", 16'h0000, wdog_done)
        `CHK("watchdog_counter_o", 16'h0001, watchdog_counter_o)
        `CHK("zero_o", 1'b1, zero_o)
    endtask : t_watchdog

    task automatic t_dec();
        // Byte at ff holds ff; memory destination must leave acc at 00
        go(CCE_OP_DECREMENT, 8'hff, 1'b1, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'h00, acc_o)
        `CHK("zero_o", 1'b0, zero_o)
        go(CCE_OP_DECREMENT, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'hfd, acc_o)
        `CHK("dec_done", 2, done_n)
    endtask : t_dec

    task automatic t_dec_skip();
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b1, 13'h0000, 13'h0000);
        go(CCE_OP_DEC_SKIP, 8'hff, 1'b1, 13'h0000, 13'h0000);
        `CHK("skip_cycle", 2, skip_n)
        `CHK("skip_done", 3, done_n)
        `CHK("skip_busy", 2, busy_n)
        `CHK("zero_o", 1'b0, zero_o)
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'hff, acc_o)
        go(CCE_OP_DECREMENT, 8'hff, 1'b1, 13'h0000, 13'h0000);
        go(CCE_OP_COMPLEMENT, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("zero_o", 1'b1, zero_o)
        go(CCE_OP_DEC_SKIP, 8'hff, 1'b0, 13'h0000, 13'h0000);
        `CHK("acc_o", 8'hfe, acc_o)
        `CHK("zero_o", 1'b1, zero_o)
        `CHK("skip_cycle", 0, skip_n)
        `CHK("noskip_done", 2, done_n)
        `CHK("noskip_busy", 1, busy_n)
    endtask : t_dec_skip

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        t_reset();
        rst_b_i = 1'b1;
        t_call();
        t_clear_comp();
        t_watchdog();
        t_dec();
        t_dec_skip();
        stop_test();
    end
endmodule : cce_exec_tb_top
